// file: rtl/afr_pkg.sv
// package for the adc and fifo readback register bank
// assumes one 250 mhz clock and a 16-bit register read port
package afr_pkg;

  // ***********************************************************
  // widths and depths
  // ***********************************************************
  localparam int DATA_W   = 16;
  localparam int ADDR_W   = 8;
  localparam int RESULT_W = 12;
  localparam int CHAR_W   = 8;
  localparam int ENTRY_W  = 9;   // parity bit above the character
  localparam int RX_DEPTH = 32;
  localparam int LEVEL_W  = 6;   // occupancy 0 to 32
  localparam int SET_W    = 4;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_ANALOG_PIN_0_RESULT  = 8'h24;
  localparam logic [7:0] OFS_ANALOG_PIN_1_RESULT  = 8'h25;
  localparam logic [7:0] OFS_TEMP_RESULT  = 8'h26;
  localparam logic [7:0] OFS_DIAG_RESULT  = 8'h27;
  localparam logic [7:0] OFS_CMP_OFFSET   = 8'h28;
  localparam logic [7:0] OFS_RX_READ_PORT = 8'h2a;
  localparam logic [7:0] OFS_FIFO_VIEW    = 8'h2b;
  localparam logic [7:0] OFS_DAC_CODE     = 8'h2c;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int RX_LEVEL_LSB = 12;
  localparam int RX_ABOVE_BIT = 11;
  localparam int RX_FULL_BIT  = 10;
  localparam int RX_EMPTY_BIT = 9;
  localparam int PARITY_BIT   = 8;
  localparam int TX_LEVEL_LSB = 4;
  localparam int TX_BELOW_BIT = 3;
  localparam int TX_FULL_BIT  = 2;
  localparam int TX_EMPTY_BIT = 1;

  // ***********************************************************
  // reset values and timing
  // ***********************************************************
  localparam logic [15:0] RST_RESULT    = 16'h0000;
  localparam logic [15:0] RST_RX_PORT   = 16'h0200;
  localparam logic [15:0] RST_FIFO_VIEW = 16'h0202;
  localparam int          READ_LATENCY  = 1;  // cycles strobe to data

endpackage : afr_pkg

// file: rtl/afr_readback_regs.sv
// readback register bank: adc results, receive fifo port, fifo view
// assumes a parallel read port decoded from the serial frame upstream
//
// Summary of operation
// - pin results in bits 11-0 each
// - latest temperature result in bits 11-0
// - diagnostic mux result in bits 11-0
// - measured comparator offset in bits 11-0
// - bypass replaces offset used, not reported
// - read port 15-12 shows pre-dequeue level halved
// - read port bit 11 above threshold
// - bits 10,9 full and empty, empty resets one
// - bit 8 returns received odd parity
// - bits 7-0 return head character
// - reads only when uart disable is one
// - status view never enqueues or dequeues
// - status view leaves sticky bits alone
// - status 15-12 receive occupancy halved
// - status 11-9 above, full, empty
// - status 7-4 transmit occupancy halved
// - status bit 3 transmit below threshold
// - status bits 2,1 transmit full, empty
// - bits 15-0 applied dac code
`timescale 1ns/1ns
module afr_readback_regs (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_in,
  // register read port
  input  wire logic                          rd_strobe_in,
  input  wire logic [afr_pkg::ADDR_W-1:0]    rd_addr_in,
  output logic      [afr_pkg::DATA_W-1:0]    rd_data_out,
  output logic                               rd_valid_out,
  // conversion results
  input  wire logic                          pin0_load_in,
  input  wire logic [afr_pkg::RESULT_W-1:0]  pin0_result_in,
  input  wire logic                          pin1_load_in,
  input  wire logic [afr_pkg::RESULT_W-1:0]  pin1_result_in,
  input  wire logic                          temp_load_in,
  input  wire logic [afr_pkg::RESULT_W-1:0]  temp_result_in,
  input  wire logic                          diag_load_in,
  input  wire logic [afr_pkg::RESULT_W-1:0]  diag_result_in,
  input  wire logic                          offset_load_in,
  input  wire logic [afr_pkg::RESULT_W-1:0]  offset_measured_in,
  // offset bypass control
  input  wire logic                          offset_bypass_enable_in,
  input  wire logic [afr_pkg::RESULT_W-1:0]  bypass_data_in,
  output logic      [afr_pkg::RESULT_W-1:0]  offset_applied_out,
  // modem receive side
  input  wire logic                          uart_disable_in,
  input  wire logic [afr_pkg::CHAR_W-1:0]    rx_char_in,
  input  wire logic                          rx_parity_in,
  input  wire logic                          rx_valid_in,
  output logic                               rx_ready_out,
  input  wire logic [afr_pkg::SET_W-1:0]     rx_level_set_in,
  // modem transmit fifo, viewed passively
  input  wire logic [afr_pkg::LEVEL_W-1:0]   tx_level_in,
  input  wire logic                          tx_full_in,
  input  wire logic                          tx_empty_in,
  input  wire logic [afr_pkg::SET_W-1:0]     tx_level_set_in,
  // dac code
  input  wire logic [afr_pkg::DATA_W-1:0]    dac_code_in
);

  // ***********************************************************
  // helper functions
  // ***********************************************************

  // widens a 12-bit result; reserved bits 15-12 read zero
  function automatic logic [afr_pkg::DATA_W-1:0] widen_result(
    input logic [afr_pkg::RESULT_W-1:0] value
  );
    widen_result = {{(afr_pkg::DATA_W-afr_pkg::RESULT_W){1'b0}}, value};
  endfunction : widen_result

  // receive flags in bits 15-9, shared by read port and view
  function automatic logic [afr_pkg::DATA_W-1:0] rx_flags(
    input logic [afr_pkg::LEVEL_W-1:0] level,
    input logic [afr_pkg::SET_W-1:0]   level_set
  );
    logic [afr_pkg::DATA_W-1:0] word;
    word = '0;
    word[afr_pkg::RX_LEVEL_LSB +: 4] = level[4:1];
    word[afr_pkg::RX_ABOVE_BIT] =
      (level > {1'b0, level_set, 1'b1});
    word[afr_pkg::RX_FULL_BIT] =
      (level == afr_pkg::LEVEL_W'(afr_pkg::RX_DEPTH));
    word[afr_pkg::RX_EMPTY_BIT] = (level == '0);
    rx_flags = word;
  endfunction : rx_flags

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic [afr_pkg::RESULT_W-1:0] pin0_value;
  logic [afr_pkg::RESULT_W-1:0] pin1_value;
  logic [afr_pkg::RESULT_W-1:0] temp_value;
  logic [afr_pkg::RESULT_W-1:0] diag_value;
  logic [afr_pkg::RESULT_W-1:0] offset_value;
  logic [afr_pkg::ENTRY_W-1:0]  rx_head;
  logic                         rx_head_valid;
  logic [afr_pkg::LEVEL_W-1:0]  rx_level;
  logic                         rx_pop;
  logic                         rx_port_hit;
  logic [afr_pkg::DATA_W-1:0]   rd_data_next;
  logic [afr_pkg::DATA_W-1:0]   rx_port_word;
  logic [afr_pkg::DATA_W-1:0]   view_word;
  logic [afr_pkg::ENTRY_W-1:0]  last_char_reg;

  // ***********************************************************
  // conversion result holders
  // ***********************************************************

  // each channel keeps its own latest result
  afr_result_hold u_pin0 (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .load_in   (pin0_load_in),
    .data_in   (pin0_result_in),
    .value_out (pin0_value)
  );

  afr_result_hold u_pin1 (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .load_in   (pin1_load_in),
    .data_in   (pin1_result_in),
    .value_out (pin1_value)
  );

  afr_result_hold u_temp (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .load_in   (temp_load_in),
    .data_in   (temp_result_in),
    .value_out (temp_value)
  );

  afr_result_hold u_diag (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .load_in   (diag_load_in),
    .data_in   (diag_result_in),
    .value_out (diag_value)
  );

  // the measured offset is stored untouched by the bypass
  afr_result_hold u_offset (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .load_in   (offset_load_in),
    .data_in   (offset_measured_in),
    .value_out (offset_value)
  );

  // ***********************************************************
  // offset applied to conversions
  // ***********************************************************

  // bypass only swaps what the converter uses, never the readback
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      offset_applied_out <= '0;
    else if (offset_bypass_enable_in)
      offset_applied_out <= bypass_data_in;
    else
      offset_applied_out <= offset_value;
  end

  // ***********************************************************
  // receive fifo
  // ***********************************************************

  // modem is stalled by rx_ready_out when all 32 entries are used
  afr_sync_fifo #(
    .WIDTH (afr_pkg::ENTRY_W),
    .DEPTH (afr_pkg::RX_DEPTH)
  ) u_rx_fifo (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .in_data_in    ({rx_parity_in, rx_char_in}),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .out_data_out  (rx_head),
    .out_valid_out (rx_head_valid),
    .out_ready_in  (rx_pop),
    .count_out     (rx_level)
  );

  // ***********************************************************
  // read decode and dequeue
  // ***********************************************************

  // a read of the port only counts with the uart path disabled
  assign rx_port_hit = rd_strobe_in
                    && (rd_addr_in == afr_pkg::OFS_RX_READ_PORT);
  assign rx_pop      = rx_port_hit && uart_disable_in;

  // the last dequeued character is repeated once the fifo drains;
  // before any arrival it is whatever reset left, i.e. zero
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      last_char_reg <= '0;
    else if (rx_pop && rx_head_valid)
      last_char_reg <= rx_head;
  end

  // ***********************************************************
  // word assembly
  // ***********************************************************

  // flags use the occupancy seen before this read's dequeue
  always_comb
  begin
    rx_port_word = rx_flags(rx_level, rx_level_set_in);
    if (rx_head_valid)
    begin
      rx_port_word[afr_pkg::PARITY_BIT] =
        rx_head[afr_pkg::CHAR_W];
      rx_port_word[afr_pkg::CHAR_W-1:0] =
        rx_head[afr_pkg::CHAR_W-1:0];
    end
    else
    begin
      rx_port_word[afr_pkg::PARITY_BIT] =
        last_char_reg[afr_pkg::CHAR_W];
      rx_port_word[afr_pkg::CHAR_W-1:0] =
        last_char_reg[afr_pkg::CHAR_W-1:0];
    end
  end

  // passive view: built from live counts only, no side effects
  always_comb
  begin
    view_word = rx_flags(rx_level, rx_level_set_in);
    view_word[afr_pkg::TX_LEVEL_LSB +: 4] =
      tx_level_in[4:1];
    view_word[afr_pkg::TX_BELOW_BIT] =
      (tx_level_in < {1'b0, tx_level_set_in, 1'b0});
    view_word[afr_pkg::TX_FULL_BIT]  = tx_full_in;
    view_word[afr_pkg::TX_EMPTY_BIT] = tx_empty_in;
  end

  // ***********************************************************
  // read data mux
  // ***********************************************************

  // unmapped offsets, 0x29 among them, read as zero
  always_comb
  begin
    if (rd_addr_in == afr_pkg::OFS_ANALOG_PIN_0_RESULT)
      rd_data_next = widen_result(pin0_value);
    else if (rd_addr_in == afr_pkg::OFS_ANALOG_PIN_1_RESULT)
      rd_data_next = widen_result(pin1_value);
    else if (rd_addr_in == afr_pkg::OFS_TEMP_RESULT)
      rd_data_next = widen_result(temp_value);
    else if (rd_addr_in == afr_pkg::OFS_DIAG_RESULT)
      rd_data_next = widen_result(diag_value);
    else if (rd_addr_in == afr_pkg::OFS_CMP_OFFSET)
      rd_data_next = widen_result(offset_value);
    else if (rd_addr_in == afr_pkg::OFS_RX_READ_PORT)
      rd_data_next = uart_disable_in ? rx_port_word
                                     : rd_data_out;
    else if (rd_addr_in == afr_pkg::OFS_FIFO_VIEW)
      rd_data_next = view_word;
    else if (rd_addr_in == afr_pkg::OFS_DAC_CODE)
      rd_data_next = dac_code_in;
    else
      rd_data_next = '0;
  end

  // ***********************************************************
  // read response registers
  // ***********************************************************

  // data stands until the next accepted read; an ignored port
  // read keeps the old word and leaves the fifo untouched
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rd_data_out <= afr_pkg::RST_RX_PORT;
    else if (rd_strobe_in)
      rd_data_out <= rd_data_next;
  end

  // one-cycle acknowledge, also given for ignored reads so the
  // serial framer never waits on a refused access
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rd_valid_out <= 1'b0;
    else
      rd_valid_out <= rd_strobe_in;
  end

endmodule : afr_readback_regs

// file: rtl/afr_result_hold.sv
// holds one 12-bit conversion result, loaded by a strobe
// assumes the strobe and data are synchronous to mclk_in
`timescale 1ns/1ns
module afr_result_hold (
  input  wire logic                         mclk_in,
  input  wire logic                         rst_in,
  input  wire logic                         load_in,
  input  wire logic [afr_pkg::RESULT_W-1:0] data_in,
  output logic      [afr_pkg::RESULT_W-1:0] value_out
);
  // latest conversion wins; no history is kept
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      value_out <= afr_pkg::RST_RESULT[afr_pkg::RESULT_W-1:0];
    else if (load_in)
      value_out <= data_in;
  end

endmodule : afr_result_hold

// file: rtl/afr_sync_fifo.sv
// synchronous fifo with valid/ready on both sides and a live count
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module afr_sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_in,
  input  wire logic [WIDTH-1:0]           in_data_in,
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  output logic [WIDTH-1:0]                out_data_out,
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0]      count_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  // full and empty come straight from the count
  assign in_ready_out  = (count_reg != CW'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
  assign count_out     = count_reg;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  // storage has no reset: contents are undefined until written
  always_ff @(posedge mclk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      if (push && !pop)
        count_reg <= count_reg + CW'(1);
      else if (pop && !push)
        count_reg <= count_reg - CW'(1);
    end
  end

endmodule : afr_sync_fifo

// file: tb/afr_host_model.sv
// host model: issues register reads on the parallel read port
// assumes one caller at a time and the one-cycle read answer
`timescale 1ns/1ns
module afr_host_model (
  input  wire logic        mclk_in,
  output logic             rd_strobe_out,
  output logic [7:0]       rd_addr_out,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in
);
  initial rd_strobe_out = 1'b0;
  initial rd_addr_out = 8'h00;
  // one strobe pulse; address held past the answer so it never glitches
  task automatic read(input logic [7:0] a, output logic [15:0] d,
                      output logic ok);
    @(posedge mclk_in);
    rd_strobe_out <= 1'b1;
    rd_addr_out <= a;
    @(posedge mclk_in);
    rd_strobe_out <= 1'b0;
    @(negedge mclk_in);
    ok = (rd_valid_in === 1'b1);
    d = rd_data_in;
  endtask : read
endmodule : afr_host_model

// file: tb/afr_readback_chk.sv
// checker for the readback bank, bound to the top module's ports
// assumes a single clock domain and synchronous reset
`timescale 1ns/1ns
module afr_readback_chk (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        rd_strobe_in,
  input wire logic [7:0]  rd_addr_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        rd_valid_out,
  input wire logic        offset_bypass_enable_in,
  input wire logic [11:0] bypass_data_in,
  input wire logic [11:0] offset_applied_out,
  input wire logic        uart_disable_in,
  input wire logic        rx_valid_in,
  input wire logic        rx_ready_out,
  input wire logic [3:0]  rx_level_set_in,
  input wire logic [5:0]  tx_level_in,
  input wire logic        tx_full_in,
  input wire logic        tx_empty_in,
  input wire logic [3:0]  tx_level_set_in,
  input wire logic [15:0] dac_code_in
);
  // ****************
  // occupancy shadow
  // ****************
  logic [5:0] cnt_reg;
  logic       push;
  logic       pop;
  assign push = rx_valid_in && rx_ready_out;
  assign pop = rd_strobe_in && rd_addr_in == 8'h2a && uart_disable_in
               && cnt_reg != 6'h00;
  // permitted pops only; a wrong pop shows later in the level fields
  always_ff @(posedge mclk_in)
    if (rst_in)
      cnt_reg <= 6'h00;
    else
      cnt_reg <= cnt_reg + {5'h00, push} - {5'h00, pop};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(a);
    rd_strobe_in && rd_addr_in == a;
  endsequence
  a_read_answer: assert property (rd_strobe_in |=> rd_valid_out)
    else $error("read not answered next cycle");
  a_no_stray: assert property (!rd_strobe_in |=> !rd_valid_out)
    else $error("read answer without request");
  a_port_flags: assert property (s_rd(8'h2a) ##0 uart_disable_in |=>
    rd_data_out[15:9] == {$past(cnt_reg[4:1]),
    $past(cnt_reg > {1'b0, rx_level_set_in, 1'b1}),
    $past(cnt_reg == 6'h20), $past(cnt_reg == 6'h00)})
    else $error("receive port flags wrong");
  a_refused_hold: assert property (s_rd(8'h2a) ##0 !uart_disable_in
    |=> $stable(rd_data_out)) else $error("ignored read changed data");
  a_ready_full: assert property (rx_ready_out == (cnt_reg != 6'h20))
    else $error("fifo ready disagrees with occupancy");
  a_view_rx: assert property (s_rd(8'h2b) |=>
    rd_data_out[15:8] == {$past(cnt_reg[4:1]),
    $past(cnt_reg > {1'b0, rx_level_set_in, 1'b1}),
    $past(cnt_reg == 6'h20), $past(cnt_reg == 6'h00), 1'b0})
    else $error("status view receive fields wrong");
  a_view_tx: assert property (s_rd(8'h2b) |=>
    rd_data_out[7:0] == {$past(tx_level_in[4:1]),
    $past(tx_level_in < {1'b0, tx_level_set_in, 1'b0}),
    $past(tx_full_in), $past(tx_empty_in), 1'b0})
    else $error("status view transmit fields wrong");
  a_dac_code: assert property (s_rd(8'h2c) |=>
    rd_data_out == $past(dac_code_in)) else $error("dac code wrong");
  a_bypass_used: assert property (!$past(rst_in) &&
    $past(offset_bypass_enable_in) |->
    offset_applied_out == $past(bypass_data_in))
    else $error("bypass value not applied");
endmodule : afr_readback_chk

// file: tb/afr_readback_regs_tb.sv
// self-checking bench for the readback register bank
// assumes host model and checker compiled before this file
`timescale 1ns/1ns
module afr_readback_regs_tb;
  logic        mclk_in = 1'b0, rst_in = 1'b1, rd_strobe, rd_valid;
  logic [7:0]  rd_addr, rx_char = 8'h00;
  logic [15:0] rd_data, dac = 16'h0000, last_d;
  logic [4:0]  ld = 5'h00;
  logic [11:0] res [0:4] = '{default: 12'h000};
  logic [11:0] byp_data = 12'h000, off_app;
  logic        byp_en = 1'b0, uart_disable = 1'b1, rx_par = 1'b0;
  logic        rx_valid = 1'b0, rx_ready, tx_full = 1'b0, tx_empty = 1'b1;
  logic [3:0]  rx_set = 4'h0, tx_set = 4'h0;
  logic [5:0]  tx_lvl = 6'h00, lv;
  logic [8:0]  q[$], last_e;
  int          n_mismatch = 0, n_tests = 0, cyc = 0, r;
  logic [7:0]  ra [0:8] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
                            8'h2a, 8'h2b, 8'h2c};
  logic [15:0] rv [0:8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
                            16'h0200, 16'h0202, 16'h0};
  always #2 mclk_in = ~mclk_in;
  afr_readback_regs afr_readback_regs_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .rd_strobe_in(rd_strobe),
    .rd_addr_in(rd_addr), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .pin0_load_in(ld[0]), .pin0_result_in(res[0]), .pin1_load_in(ld[1]),
    .pin1_result_in(res[1]), .temp_load_in(ld[2]),
    .temp_result_in(res[2]), .diag_load_in(ld[3]),
    .diag_result_in(res[3]), .offset_load_in(ld[4]),
    .offset_measured_in(res[4]), .offset_bypass_enable_in(byp_en),
    .bypass_data_in(byp_data), .offset_applied_out(off_app),
    .uart_disable_in(uart_disable), .rx_char_in(rx_char),
    .rx_parity_in(rx_par), .rx_valid_in(rx_valid),
    .rx_ready_out(rx_ready), .rx_level_set_in(rx_set),
    .tx_level_in(tx_lvl), .tx_full_in(tx_full), .tx_empty_in(tx_empty),
    .tx_level_set_in(tx_set), .dac_code_in(dac));
  afr_host_model afr_host_model_i (.mclk_in(mclk_in),
    .rd_strobe_out(rd_strobe), .rd_addr_out(rd_addr),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid));
  // expected receive port word for an occupancy and head entry
  function automatic logic [15:0] exp_port(int c, logic [8:0] e);
    return {c[4:1], c > {rx_set, 1'b1}, c == 32, c == 0, e};
  endfunction : exp_port
  // expected status view for a receive occupancy
  function automatic logic [15:0] exp_view(int c);
    return {c[4:1], c > {rx_set, 1'b1}, c == 32, c == 0, 1'b0,
            tx_lvl[4:1], tx_lvl < {tx_set, 1'b0}, tx_full, tx_empty, 1'b0};
  endfunction : exp_view
  task automatic check(string w, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  // one read through the host model, answer and word both compared
  task automatic rdc(logic [7:0] a, logic [15:0] e, string w);
    logic ok;
    afr_host_model_i.read(a, last_d, ok);
    check("read answer", {15'h0, ok}, 16'h1);
    check(w, last_d, e);
  endtask : rdc
  // modem push: valid held until taken, lines scrambled once released
  task automatic push(logic [8:0] e);
    int n;
    n = 0;
    @(posedge mclk_in);
    rx_valid <= 1'b1;
    {rx_par, rx_char} <= e;
    @(negedge mclk_in);
    while (rx_ready !== 1'b1 && n < 200)
    begin
      n++;
      @(negedge mclk_in);
    end
    @(posedge mclk_in);
    rx_valid <= 1'b0;
    {rx_par, rx_char} <= ~e;
    q.push_back(e);
    if (n >= 200) n_mismatch++;
  endtask : push
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    r = $urandom(51);
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++)
      rdc(ra[i], rv[i], "reset value");
    $display("test reset done");
    for (int i = 0; i < 15; i++)
    begin
      @(posedge mclk_in);
      res[i % 5] <= (i < 5) ? 12'hfff : 12'($urandom);
      ld[i % 5] <= 1'b1;
      byp_en <= 1'($urandom);
      byp_data <= 12'($urandom);
      dac <= 16'($urandom);
      @(posedge mclk_in);
      ld <= 5'h00;
      rdc(8'h24 + 8'(i % 5), {4'h0, res[i % 5]}, "result");
      rdc(8'h2c, dac, "dac code");
      check("applied offset", {4'h0, off_app},
            {4'h0, byp_en ? byp_data : res[4]});
    end
    $display("test results done");
    rx_set <= 4'($urandom);
    repeat (32) push(9'($urandom));
    rdc(8'h2b, exp_view(32), "view full");
    uart_disable <= 1'b0;
    rdc(8'h2a, last_d, "ignored read");
    rdc(8'h2b, exp_view(32), "view after ignored");
    uart_disable <= 1'b1;
    fork
      push(9'h1a5);
      begin
        @(negedge mclk_in);
        check("ready when full", {15'h0, rx_ready}, 16'h0);
        rdc(8'h2a, exp_port(32, q[0]), "pop full");
        last_e = q.pop_front();
      end
    join
    while (q.size() > 0)
    begin
      rdc(8'h2a, exp_port(q.size(), q[0]), "pop");
      last_e = q.pop_front();
    end
    rdc(8'h2a, exp_port(0, last_e), "pop empty");
    $display("test receive fifo done");
    for (int i = 0; i < 12; i++)
    begin
      // full and empty settle with the level, two cycles before the read strobe
      @(posedge mclk_in);
      lv = (i == 0) ? 6'h00 : (i == 1) ? 6'h20 : 6'($urandom_range(32));
      tx_lvl <= lv;
      tx_set <= (i == 0) ? 4'h0 : 4'($urandom);
      tx_full <= (lv == 6'h20);
      tx_empty <= (lv == 6'h00);
      @(posedge mclk_in);
      @(negedge mclk_in);
      rdc(8'h2b, exp_view(0), "view transmit");
    end
    $display("test transmit view done");
    results();
  end
endmodule : afr_readback_regs_tb
bind afr_readback_regs afr_readback_chk afr_readback_chk_i (
  .mclk_in(mclk_in), .rst_in(rst_in), .rd_strobe_in(rd_strobe_in),
  .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out),
  .offset_bypass_enable_in(offset_bypass_enable_in),
  .bypass_data_in(bypass_data_in), .offset_applied_out(offset_applied_out),
  .uart_disable_in(uart_disable_in), .rx_valid_in(rx_valid_in),
  .rx_ready_out(rx_ready_out), .rx_level_set_in(rx_level_set_in),
  .tx_level_in(tx_level_in), .tx_full_in(tx_full_in),
  .tx_empty_in(tx_empty_in), .tx_level_set_in(tx_level_set_in),
  .dac_code_in(dac_code_in));
